/* core/async_serial_tx_events.sv */
// Asynchronous serial transmitter with data-empty and transmission-done events.
`timescale 1ns/100ps
`default_nettype none
`include "uart_tx_regs.svh"
// Functional notes
// - While transmission is off the output line is left undriven.
// - With the data-empty request enable on, turning transmission on sets the data-empty pending flag and raises that event.
// - Each hand-off from the data buffer to the shift register raises the data-empty event.
// - With the data-empty request enable off no data-empty event is raised.
// - Once the last frame is fully out and nothing waits, the done event is raised.
// - Turning transmission off clears the done pending flag and floats the line.
// - The done request is forwarded only while its request enable is on.
// - Frames carry 7, 8 or 9 data bits, none/even/odd parity, 1 or 2 stops, either order.
// - With both speed selects low the bit rate is the clock over 32 times divider plus one.
module async_serial_tx_events #(
    parameter int DIV_W = `TX_DIV_W
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  tx_on_bit,
    input  wire logic                  tx_empty_req_enable,
    input  wire logic                  tx_done_req_enable,
    input  wire logic [1:0]            data_len_sel,
    input  wire logic [1:0]            parity_mode,
    input  wire logic                  two_stop_bits,
    input  wire logic                  msb_first,
    input  wire logic                  double_speed_baud_select,
    input  wire logic                  bit_sample_clock_select,
    input  wire logic [DIV_W-1:0]      baud_divider,
    input  wire logic [`TX_DATA_W-1:0] tx_data,
    input  wire logic                  tx_data_write,
    input  wire logic                  tx_empty_pending_clear,
    input  wire logic                  tx_done_pending_clear,
    output var  logic                  txd_out,
    output var  logic                  txd_oe,
    output var  logic                  tx_empty_event,
    output var  logic                  tx_done_event,
    output var  logic                  tx_empty_pending,
    output var  logic                  tx_done_pending,
    output var  logic                  tx_buffer_full
);
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div_w
        $error("DIV_W must lie between 1 and 16.");
    end

    baud_if #(.DIV_W(DIV_W)) bif ();

    baud_tick_gen #(.DIV_W(DIV_W)) u_baud (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .bif     (bif.gen)
    );

    uart_tx_pkg::tx_state_t state_reg;
    uart_tx_pkg::tx_state_t state_next;
    logic [`TX_DATA_W-1:0]  buf_reg;
    logic [`TX_DATA_W-1:0]  shift_reg;
    logic [`TX_CNT_W-1:0]   cnt_reg;
    logic [`TX_CNT_W-1:0]   cnt_next;
    logic                   on_reg;
    logic [1:0]             len_reg;
    logic [1:0]             pmode_reg;
    logic                   stop2_reg;
    logic                   msb_reg;
    logic                   line_next;

    wire [`TX_CNT_W-1:0]    nbits;
    wire [`TX_CNT_W-1:0]    bit_idx;
    wire [`TX_DATA_W-1:0]   masked;
    wire                    data_bit;
    wire                    par_bit;
    wire                    on_rise;
    wire                    idle;
    wire                    load;
    wire                    last_data;
    wire                    last_stop;
    wire                    frame_end;
    wire                    empty_raise;
    wire                    done_set;

    assign nbits     = (len_reg == `TX_LEN_7) ? `TX_BITS_7 :
                       (len_reg == `TX_LEN_9) ? `TX_BITS_9 : `TX_BITS_8;
    assign bit_idx   = msb_reg ? (nbits - cnt_next - 1'b1) : cnt_next;
    assign data_bit  = shift_reg[bit_idx];
    genvar gi;
    generate
        for (gi = 0; gi < `TX_DATA_W; gi++) begin : g_mask
            assign masked[gi] = (gi < nbits) ? shift_reg[gi] : 1'b0;
        end
    endgenerate
    assign par_bit   = (pmode_reg == `TX_PAR_ODD) ? ~(^masked) : (^masked);
    assign on_rise   = tx_on_bit && !on_reg;
    assign idle      = (state_reg == uart_tx_pkg::ST_IDLE);
    assign load      = on_reg && tx_on_bit && idle && tx_buffer_full;
    assign last_data = (cnt_reg == nbits - 1'b1);
    assign last_stop = two_stop_bits_q(stop2_reg, cnt_reg);
    assign frame_end = (state_reg == uart_tx_pkg::ST_STOP) && bif.tick && last_stop;
    assign empty_raise = (on_rise || load) && tx_empty_req_enable;
    assign done_set  = frame_end && !tx_buffer_full && tx_on_bit;

    function automatic logic two_stop_bits_q(input logic two, input logic [`TX_CNT_W-1:0] c);
        two_stop_bits_q = two ? (c != '0) : 1'b1;
    endfunction

    // The bit clock restarts with every frame so that the start bit has its full length.
    assign bif.run     = !idle;
    assign bif.divider = baud_divider;
    assign bif.speed   = (double_speed_baud_select && bit_sample_clock_select) ?
                         uart_tx_pkg::SPEED_X8 :
                         (double_speed_baud_select || bit_sample_clock_select) ?
                         uart_tx_pkg::SPEED_X16 : uart_tx_pkg::SPEED_X32;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            uart_tx_pkg::ST_IDLE: begin
                if (load) begin
                    state_next = uart_tx_pkg::ST_START;
                    cnt_next   = '0;
                end
            end
            uart_tx_pkg::ST_START: begin
                if (bif.tick) begin
                    state_next = uart_tx_pkg::ST_DATA;
                end
            end
            uart_tx_pkg::ST_DATA: begin
                if (bif.tick) begin
                    cnt_next = last_data ? '0 : cnt_reg + 1'b1;
                    if (last_data) begin
                        state_next = (pmode_reg == `TX_PAR_NONE) ?
                                     uart_tx_pkg::ST_STOP : uart_tx_pkg::ST_PARITY;
                    end
                end
            end
            uart_tx_pkg::ST_PARITY: begin
                if (bif.tick) begin
                    state_next = uart_tx_pkg::ST_STOP;
                end
            end
            uart_tx_pkg::ST_STOP: begin
                if (bif.tick) begin
                    cnt_next = cnt_reg + 1'b1;
                    if (last_stop) begin
                        state_next = uart_tx_pkg::ST_IDLE;
                    end
                end
            end
        endcase
        if (!tx_on_bit) begin
            state_next = uart_tx_pkg::ST_IDLE;
        end
    end

    always_comb begin
        unique case (state_next)
            uart_tx_pkg::ST_START:  line_next = `TX_LINE_START;
            uart_tx_pkg::ST_DATA:   line_next = data_bit;
            uart_tx_pkg::ST_PARITY: line_next = par_bit;
            uart_tx_pkg::ST_IDLE,
            uart_tx_pkg::ST_STOP:   line_next = `TX_LINE_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= uart_tx_pkg::ST_IDLE;
            cnt_reg   <= '0;
            on_reg    <= 1'b0;
            txd_out   <= `TX_LINE_IDLE;
            txd_oe    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            on_reg    <= tx_on_bit;
            txd_out   <= line_next;
            txd_oe    <= tx_on_bit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buf_reg        <= '0;
            shift_reg      <= '0;
            tx_buffer_full <= 1'b0;
            len_reg        <= `TX_LEN_8;
            pmode_reg      <= `TX_PAR_NONE;
            stop2_reg      <= 1'b0;
            msb_reg        <= 1'b0;
        end else begin
            if (load) begin
                shift_reg <= buf_reg;
                len_reg   <= data_len_sel;
                pmode_reg <= parity_mode;
                stop2_reg <= two_stop_bits;
                msb_reg   <= msb_first;
            end
            if (tx_data_write && tx_on_bit) begin
                buf_reg <= tx_data;
            end
            tx_buffer_full <= tx_on_bit && ((tx_data_write) || (tx_buffer_full && !load));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_empty_event   <= 1'b0;
            tx_done_event    <= 1'b0;
            tx_empty_pending <= 1'b0;
            tx_done_pending  <= 1'b0;
        end else begin
            tx_empty_event   <= empty_raise;
            tx_empty_pending <= empty_raise || (tx_empty_pending && !tx_empty_pending_clear);
            tx_done_event    <= done_set && tx_done_req_enable;
            if (!tx_on_bit) begin
                tx_done_pending <= 1'b0;
            end else begin
                tx_done_pending <= (done_set && tx_done_req_enable) ||
                                   (tx_done_pending && !tx_done_pending_clear);
            end
        end
    end
endmodule
`default_nettype wire

/* core/baud_if.sv */
// Interface between the frame engine and the bit-rate tick generator.
`timescale 1ns/100ps
`default_nettype none
`include "uart_tx_regs.svh"
interface baud_if #(parameter int DIV_W = `TX_DIV_W);
    logic                    run;
    uart_tx_pkg::speed_t     speed;
    logic [DIV_W-1:0]        divider;
    logic                    tick;

    modport gen  (input run, input speed, input divider, output tick);
    modport user (output run, output speed, output divider, input tick);
endinterface
`default_nettype wire

/* core/baud_tick_gen.sv */
// Bit-rate tick generator: one tick every prescale times (divider plus one) clocks.
`timescale 1ns/100ps
`default_nettype none
`include "uart_tx_regs.svh"
module baud_tick_gen #(
    parameter int DIV_W = `TX_DIV_W
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    baud_if.gen       bif
);
    logic [`TX_PRE_W-1:0] pre_reg;
    logic [DIV_W-1:0]     div_reg;
    logic                 tick_reg;
    wire  [`TX_PRE_W-1:0] pre_top;
    wire                  pre_wrap;
    wire                  div_wrap;

    // The prescale follows the double-speed and sample-clock selects.
    assign pre_top  = (bif.speed == uart_tx_pkg::SPEED_X8)  ? `TX_PRE_8 :
                      (bif.speed == uart_tx_pkg::SPEED_X16) ? `TX_PRE_16 : `TX_PRE_32;
    assign pre_wrap = (pre_reg == pre_top);
    assign div_wrap = (div_reg == bif.divider);
    assign bif.tick = tick_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg  <= '0;
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (!bif.run) begin
            // The registered tick costs one clock, so the prescaler starts one step ahead.
            pre_reg  <= `TX_PRE_START;
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_wrap ? '0 : pre_reg + 1'b1;
            if (pre_wrap) begin
                div_reg <= div_wrap ? '0 : div_reg + 1'b1;
            end
            tick_reg <= pre_wrap && div_wrap;
        end
    end
endmodule
`default_nettype wire

/* core/uart_tx_pkg.sv */
// Types shared by the asynchronous serial transmitter.
package uart_tx_pkg;
    typedef enum logic [1:0] {
        SPEED_X32,
        SPEED_X16,
        SPEED_X8
    } speed_t;

    typedef enum {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PARITY,
        ST_STOP
    } tx_state_t;
endpackage

/* core/uart_tx_regs.svh */
// Constants for the asynchronous serial transmitter.
`ifndef UART_TX_REGS_SVH
`define UART_TX_REGS_SVH

`define TX_DATA_W       9
`define TX_DIV_W        8
`define TX_CNT_W        4
`define TX_LEN_7        2'h0
`define TX_LEN_8        2'h1
`define TX_LEN_9        2'h2
`define TX_BITS_7       4'h7
`define TX_BITS_8       4'h8
`define TX_BITS_9       4'h9
`define TX_PAR_NONE     2'h0
`define TX_PAR_EVEN     2'h1
`define TX_PAR_ODD      2'h2
`define TX_PRE_W        5
`define TX_PRE_32       5'h1F
`define TX_PRE_16       5'h0F
`define TX_PRE_8        5'h07
`define TX_PRE_START    5'h01
`define TX_LINE_IDLE    1'h1
`define TX_LINE_START   1'h0

`endif

/* verif/async_serial_tx_events_properties.sv */
// Port-level checks for the serial transmitter.
`timescale 1ns/100ps
`default_nettype none
module async_serial_tx_events_properties (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tx_on_bit,
    input wire logic tx_empty_req_enable,
    input wire logic tx_done_req_enable,
    input wire logic txd_out,
    input wire logic txd_oe,
    input wire logic tx_empty_event,
    input wire logic tx_done_event,
    input wire logic tx_empty_pending,
    input wire logic tx_done_pending,
    input wire logic tx_buffer_full
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_line_driven_on: assert property (tx_on_bit |=> txd_oe)
        else $error("line undriven while on");
    a_line_float_off: assert property (!tx_on_bit |=> !txd_oe && !tx_done_pending)
        else $error("line or done flag wrong while off");
    a_empty_on_start: assert property ($rose(tx_on_bit) && tx_empty_req_enable
        |=> tx_empty_event && tx_empty_pending) else $error("no empty event at start");
    a_empty_on_load: assert property ($fell(tx_buffer_full) && $past(tx_on_bit)
        && $past(tx_empty_req_enable) |-> tx_empty_event) else $error("no empty event at load");
    a_empty_gated: assert property (!tx_empty_req_enable |=> !tx_empty_event)
        else $error("empty event while disabled");
    a_done_gated: assert property (!tx_done_req_enable |=> !tx_done_event)
        else $error("done event while disabled");
    a_done_when_idle: assert property (tx_done_event
        |-> txd_out && !$past(tx_buffer_full) && $past(txd_out, 8))
        else $error("early done event");
    a_frame_starts_low: assert property ($fell(tx_buffer_full) && $past(tx_on_bit)
        |-> !txd_out) else $error("no start bit");
    a_done_sets_flag: assert property (tx_done_event |-> tx_done_pending)
        else $error("done event without pending flag");
endmodule
`default_nettype wire

/* verif/serial_rx_model.sv */
// Remote receiver model decoding frames from the pulled-up line.
`timescale 1ns/100ps
`default_nettype none
module serial_line_model (
    input  wire logic       clk_sys,
    input  wire logic       line,
    input  var  int         bit_clks,
    input  var  int         nbits,
    output var  logic [9:0] got_word,
    output var  logic       got_stop,
    output var  int         got_count
);
    initial got_count = 0;
    always begin
        @(negedge line);
        got_word = 10'h000;
        repeat (bit_clks / 2) @(posedge clk_sys);
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge clk_sys);
            got_word[i] = line;
        end
        repeat (bit_clks) @(posedge clk_sys);
        got_stop = line;
        got_count++;
    end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the serial transmitter.
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct packed {logic [7:0] cfg; logic [8:0] d; logic [9:0] exp;} row_t;
    logic       clk_sys = 0, rst_n = 0, on = 0, een = 0, den = 0, stop2 = 0, msb = 0;
    logic       dbl = 0, samp = 0, wr = 0, txd_out, txd_oe, ev_e, ev_d, pend_e, pend_d;
    logic       full, line, got_stop, clr_e = 0, clr_d = 0;
    logic [1:0] len = 2'h1, par = 2'h0;
    logic [7:0] div = 8'h01;
    logic [8:0] data = 9'h000;
    logic [9:0] got_word;
    int         mismatches = 0, n_tests = 0, bit_clks = 64, nbits = 8, got_count;
    int         n_e = 0, n_d = 0, e0, d0, r0;
    // Config is length, parity, two stops, MSB first, both speed selects.
    row_t rows[4] = '{'{8'h40, 9'h0A5, 10'h0A5}, '{8'h1A, 9'h053, 10'h053},
                      '{8'hA7, 9'h1C6, 10'h0C7}, '{8'h6D, 9'h081, 10'h181}};
    always #12.5 clk_sys = ~clk_sys;
    assign line = txd_oe ? txd_out : 1'b1;
    always @(posedge clk_sys) begin
        n_e += int'(ev_e);
        n_d += int'(ev_d);
    end
    async_serial_tx_events i_async_serial_tx_events (.clk_sys(clk_sys), .rst_n(rst_n),
        .tx_on_bit(on), .tx_empty_req_enable(een), .tx_done_req_enable(den),
        .data_len_sel(len), .parity_mode(par), .two_stop_bits(stop2), .msb_first(msb),
        .double_speed_baud_select(dbl), .bit_sample_clock_select(samp),
        .baud_divider(div), .tx_data(data), .tx_data_write(wr),
        .tx_empty_pending_clear(clr_e), .tx_done_pending_clear(clr_d), .txd_out(txd_out),
        .txd_oe(txd_oe), .tx_empty_event(ev_e), .tx_done_event(ev_d),
        .tx_empty_pending(pend_e), .tx_done_pending(pend_d), .tx_buffer_full(full));
    serial_line_model i_serial_line_model (.clk_sys(clk_sys), .line(line),
        .bit_clks(bit_clks), .nbits(nbits), .got_word(got_word), .got_stop(got_stop),
        .got_count(got_count));
    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_n(input string nm, input int exp, input int got);
        n_tests++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic wait_cnt(ref int c, input int t);
        for (int j = 0; j < 4000 && c < t; j++) @(negedge clk_sys);
        if (c < t) begin
            mismatches++;
            $display("MISMATCH wait expected %0d seen %0d", t, c);
        end
    endtask
    task automatic send(input logic [8:0] d);
        @(negedge clk_sys);
        data = d;
        wr = 1;
        @(negedge clk_sys);
        wr = 0;
    endtask
    task automatic start(input row_t r);
        {len, par, stop2, msb, dbl, samp} = r.cfg;
        bit_clks = (32 >> (int'(dbl) + int'(samp))) * (int'(div) + 1);
        nbits = 7 + int'(len) + int'(par != 2'h0);
        e0 = n_e;
        d0 = n_d;
        r0 = got_count;
        on = 1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        rst_n = 1;
        foreach (rows[i]) begin
            een = 1;
            den = 1;
            start(rows[i]);
            wait_cnt(n_e, e0 + 1);
            chk_n("empty at enable", e0 + 1, n_e);
            chk("empty pending", 10'h001, {9'h000, pend_e});
            send(rows[i].d);
            een = 0;
            wait_cnt(got_count, r0 + 1);
            chk("frame bits", rows[i].exp, got_word);
            chk("stop level", 10'h001, {9'h000, got_stop});
            wait_cnt(n_d, d0 + 1);
            chk_n("done event", d0 + 1, n_d);
            chk_n("empty after last", e0 + 1, n_e);
            chk("done pending", 10'h001, {9'h000, pend_d});
            on = 0;
            den = 0;
            @(negedge clk_sys);
            chk("off state", 10'h002, {7'h00, txd_oe, line, pend_d});
            $display("frame case %0d finished", i);
        end
        een = 1;
        den = 1;
        start(rows[0]);
        wait_cnt(n_e, e0 + 1);
        send(9'h03C);
        wait_cnt(n_e, e0 + 2);
        send(9'h0C3);
        een = 0;
        chk("buffer holds byte", 10'h001, {9'h000, full});
        wait_cnt(got_count, r0 + 2);
        chk("second frame", 10'h0C3, got_word);
        chk_n("empty at hand-off", e0 + 2, n_e);
        wait_cnt(n_d, d0 + 1);
        repeat (100) @(negedge clk_sys);
        chk_n("single done", d0 + 1, n_d);
        clr_e = 1;
        clr_d = 1;
        @(negedge clk_sys);
        clr_e = 0;
        clr_d = 0;
        chk("pending cleared", 10'h000, {8'h00, pend_e, pend_d});
        on = 0;
        den = 0;
        @(negedge clk_sys);
        $display("back to back case finished");
        start(rows[0]);
        send(9'h055);
        wait_cnt(got_count, r0 + 1);
        repeat (100) @(negedge clk_sys);
        chk_n("done gated", d0, n_d);
        chk_n("empty gated", e0, n_e);
        send(9'h000);
        repeat (300) @(negedge clk_sys);
        on = 0;
        @(negedge clk_sys);
        chk("abort state", 10'h002, {7'h00, txd_oe, line, pend_d});
        $display("gated and abort case finished");
        summarize();
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        $display("watchdog expired");
        summarize();
    end
endmodule
bind async_serial_tx_events async_serial_tx_events_properties i_props (.clk_sys(clk_sys),
    .rst_n(rst_n), .tx_on_bit(tx_on_bit), .tx_empty_req_enable(tx_empty_req_enable),
    .tx_done_req_enable(tx_done_req_enable), .txd_out(txd_out), .txd_oe(txd_oe),
    .tx_empty_event(tx_empty_event), .tx_done_event(tx_done_event),
    .tx_empty_pending(tx_empty_pending), .tx_done_pending(tx_done_pending),
    .tx_buffer_full(tx_buffer_full));
`default_nettype wire
